// ---- core_model.sv ----
// Purpose: processor core that takes vectored requests
// Assumes: ack is one cycle wide and only raised while irq is high
// Notes:   random wait of 0 to 3 cycles before each ack
module core_model (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // vector handshake
  input  wire logic irq_i,
  output logic      ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned wait_cnt;

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o    <= 1'b0;
      wait_cnt <= 0;
    end else if (ack_o) begin
      ack_o    <= 1'b0;
      wait_cnt <= $urandom_range(3, 0);
    end else if (irq_i) begin
      if (wait_cnt == 0) ack_o <= 1'b1;
      else wait_cnt <= wait_cnt - 1;
    end
  end
endmodule

// ---- irq_ctrl_monitor.sv ----
// Purpose: port checks of the vector interrupt controller
// Assumes: single clock domain
// Notes:   reset disables every check
module irq_ctrl_monitor (
  // clock and reset
  input wire logic        clock_i,
  input wire logic        rst_i,
  // register bus
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic [15:0] s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  // requests and core
  input wire logic [27:0] src_req_i,
  input wire logic        vector_ack_i,
  input wire logic        irq_o,
  input wire logic [15:0] vector_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  a_vector_range: assert property (irq_o |-> !vector_o[0] && vector_o >= 16'h0004 && vector_o <= 16'h0036)
    else $error("vector outside the table");
  a_trap_served: assert property (src_req_i[3] |=> irq_o && vector_o <= 16'h0006)
    else $error("trap not presented");
  a_ack_clears: assert property (vector_ack_i && irq_o && vector_o == 16'h0016 && !src_req_i[11]
    |=> !irq_o || vector_o != 16'h0016) else $error("taken pulse vector still shown");
  a_vector_hold: assert property (!irq_o ##1 !irq_o |-> $stable(vector_o))
    else $error("vector moved while idle");
  a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    && !s_axi_bvalid_o |-> ##2 s_axi_bvalid_o) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_read_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_read_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read accepted while answer pending");
  a_misaligned_error: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[1:0] != 2'b00
    |=> s_axi_rresp_o == 2'b10) else $error("misaligned read not refused");
endmodule

bind vector_irq_ctrl irq_ctrl_monitor mon (.clock_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .src_req_i, .vector_ack_i, .irq_o, .vector_o);

// ---- irq_ctrl_pkg.sv ----
// Purpose: types shared by the vector interrupt controller
// Assumes: 28 slots, slot number fits five bits
// Notes:   constants live in irq_ctrl_regs.svh
package irq_ctrl_pkg;

  typedef logic [27:0] pend_t;
  typedef logic [4:0]  slot_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_full;
    logic [15:0] aw_addr;
    logic        w_full;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [7:0]  rdata;
    pend_t       pend;
    logic [7:0]  port_sel;
    logic        gie;
    logic        irq;
    slot_t       slot;
  } ctrl_state_t;

endpackage

// ---- irq_ctrl_regs.svh ----
// Purpose: register indexes, field positions, reset values and slot numbers of the vector interrupt controller
// Assumes: byte address of a register is four times its index
// Notes:   slot n is served at program memory vector 2*n
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH

// register indexes
`define PEND_LOW_IDX    12'hfc0
`define PEND_PIN_IDX    12'hfc3
`define PEND_HIGH_IDX   12'hfc6
`define PORT_SEL_IDX    12'hfcd
`define CTRL_IDX        12'hfcf
`define STATUS_IDX      12'hfd0

// reset values
`define PEND_RESET      28'h0000000
`define PORT_SEL_RESET  8'h00
`define CTRL_RESET      8'h00

// fields
`define CTRL_GIE_BIT    0
`define STAT_IRQ_BIT    7
`define STAT_TRAP_BIT   6
`define STAT_WDT_BIT    5

// slots, highest priority first
`define SLOT_RESET      1
`define SLOT_WDT        2
`define SLOT_TRAP       3
`define SLOT_LOW_BASE   4
`define SLOT_PIN7       12
`define SLOT_PIN0       19
`define SLOT_TIMER3     20
`define SLOT_HIGH_BASE  20
`define SLOT_PORTC3     24
`define SLOT_LAST       27
`define SLOT_COUNT      28

// slot groups
`define MASKABLE_SLOTS  28'hffffff4
`define TRAP_SLOTS      28'h0000008

// bus answers
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// ---- irq_pick_if.sv ----
// Purpose: carries the eligible requests to the priority picker and the winner back
// Assumes: lowest slot number has highest priority
// Notes:   purely combinational signals
interface irq_pick_if;
  irq_ctrl_pkg::pend_t req;
  logic                hit;
  irq_ctrl_pkg::slot_t slot;

  modport picker (input req, output hit, output slot);
  modport user   (output req, input hit, input slot);
endinterface

// ---- irq_priority_pick.sv ----
// Purpose: fixed priority encoder over the slot vector
// Assumes: request bit n belongs to slot n
// Notes:   scans from the lowest priority upward so the highest priority wins
`include "irq_ctrl_regs.svh"

module irq_priority_pick (
  irq_pick_if.picker pick
);

  always_comb begin
    pick.hit  = 1'b0;
    pick.slot = '0;
    for (int s = `SLOT_LAST; s >= 0; s--) begin
      if (pick.req[s]) begin
        pick.hit  = 1'b1;
        pick.slot = 5'(s);
      end
    end
  end

endmodule

// ---- pin_edge_detect.sv ----
// Purpose: synchronises port pins and flags any change of level
// Assumes: pins are asynchronous to clock_i
// Notes:   edges are held off until the synchroniser has filled after reset
module pin_edge_detect #(
  parameter int WIDTH = 20
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  // pins and edges
  input  wire logic [WIDTH-1:0] pins_i,
  output logic      [WIDTH-1:0] edge_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
    logic [1:0]       warm;
  } edge_state_t;

  edge_state_t st_reg;
  edge_state_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.meta = pins_i;
    st_next.sync = st_reg.meta;
    st_next.prev = st_reg.sync;
    if (st_reg.warm != 2'h3) begin
      st_next.warm = st_reg.warm + 2'h1;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // rising and falling edges alike
  assign edge_o = (st_reg.warm == 2'h3) ? (st_reg.sync ^ st_reg.prev) : '0;

endmodule

// ---- vector_irq_ctrl.sv ----
// Purpose: fixed priority vectored interrupt controller with AXI4-Lite register access
// Assumes: peripheral requests are on clock_i; port pins are asynchronous
// Notes:   a request is sticky until the core takes its vector or, for slots 4 to 27, software writes 1 to its bit
`include "irq_ctrl_regs.svh"

module vector_irq_ctrl #(
  parameter bit HAS_TIMER3 = 1'b1
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // AXI4-Lite write address
  input  wire logic [15:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read address
  input  wire logic [15:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // peripheral requests, bit n drives slot n for slots 2 to 11 and 20 to 23
  input  wire logic [27:0] src_req_i,
  // port pins
  input  wire logic [7:0]  port_a_i,
  input  wire logic [7:0]  port_d_i,
  input  wire logic [3:0]  port_c_i,
  // processor core
  input  wire logic        vector_ack_i,
  output logic             irq_o,
  output logic [15:0]      vector_o
);

  irq_ctrl_pkg::ctrl_state_t st_reg;
  irq_ctrl_pkg::ctrl_state_t st_next;

  logic [19:0]         pin_edge;
  irq_ctrl_pkg::pend_t set_vec;
  irq_ctrl_pkg::pend_t ack_clr;
  irq_ctrl_pkg::pend_t wr_clr;
  irq_ctrl_pkg::pend_t pend_next;
  irq_ctrl_pkg::pend_t eligible;
  logic                do_write;
  logic                wr_addr_ok;
  logic [11:0]         wr_idx;

  irq_pick_if pick_bus ();

  // pins A 7..0, D 7..0, C 3..0
  pin_edge_detect #(
    .WIDTH (20)
  ) u_edges (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pins_i  ({port_c_i, port_d_i, port_a_i}),
    .edge_o  (pin_edge)
  );

  irq_priority_pick u_pick (
    .pick (pick_bus)
  );

  // gather eight slots into a register byte, bit b is slot base+7-b
  function automatic logic [7:0] pend_byte(input irq_ctrl_pkg::pend_t p, input int base);
    logic [7:0] r;
    r = '0;
    for (int b = 0; b < 8; b++) begin
      r[b] = p[base + 7 - b];
    end
    return r;
  endfunction

  // spread a register byte back onto its slots
  function automatic irq_ctrl_pkg::pend_t pend_spread(input logic [7:0] d, input int base);
    irq_ctrl_pkg::pend_t r;
    r = '0;
    for (int b = 0; b < 8; b++) begin
      r[base + 7 - b] = d[b];
    end
    return r;
  endfunction

  // request sources per slot
  for (genvar s = 0; s < `SLOT_COUNT; s++) begin : g_set
    if (s >= `SLOT_PIN7 && s <= `SLOT_PIN0) begin : g_pin
      assign set_vec[s] = st_reg.port_sel[`SLOT_PIN0 - s]
                        ? pin_edge[8 + `SLOT_PIN0 - s]
                        : pin_edge[`SLOT_PIN0 - s];
    end else if (s >= `SLOT_PORTC3) begin : g_portc
      assign set_vec[s] = pin_edge[16 + `SLOT_LAST - s];
    end else if (s <= `SLOT_RESET) begin : g_none
      assign set_vec[s] = 1'b0;
    end else if (s == `SLOT_TIMER3) begin : g_timer3
      assign set_vec[s] = HAS_TIMER3 & src_req_i[s];
    end else begin : g_periph
      assign set_vec[s] = src_req_i[s];
    end
  end

  // write decode
  assign do_write   = st_reg.aw_full & st_reg.w_full & ~st_reg.bvalid;
  assign wr_idx     = st_reg.aw_addr[13:2];
  assign wr_addr_ok = (st_reg.aw_addr[1:0] == 2'h0) & (st_reg.aw_addr[15:14] == 2'h0);

  // clears from the core taking a vector and from software
  always_comb begin
    ack_clr = '0;
    if (st_reg.irq && vector_ack_i) begin
      ack_clr[st_reg.slot] = 1'b1;
    end
  end

  always_comb begin
    wr_clr = '0;
    if (do_write && wr_addr_ok && st_reg.w_lane0) begin
      unique case (wr_idx)
        `PEND_LOW_IDX:  wr_clr = pend_spread(st_reg.w_data, `SLOT_LOW_BASE);
        `PEND_PIN_IDX:  wr_clr = pend_spread(st_reg.w_data, `SLOT_PIN7);
        `PEND_HIGH_IDX: wr_clr = pend_spread(st_reg.w_data, `SLOT_HIGH_BASE);
        default:        wr_clr = '0;
      endcase
    end
  end

  // a set arriving with its clear wins; held requests set again at once
  assign pend_next = (st_reg.pend & ~(ack_clr | wr_clr)) | set_vec;

  // trap ignores the global enable, the rest need it
  assign eligible = (pend_next & `TRAP_SLOTS)
                  | (st_reg.gie ? (pend_next & `MASKABLE_SLOTS) : '0);

  assign pick_bus.req = eligible;

  always_comb begin
    st_next      = st_reg;
    st_next.pend = pend_next;

    // write channels taken in either order
    if (st_reg.awready && s_axi_awvalid_i) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = s_axi_awaddr_i;
    end
    if (st_reg.wready && s_axi_wvalid_i) begin
      st_next.w_full  = 1'b1;
      st_next.w_data  = s_axi_wdata_i[7:0];
      st_next.w_lane0 = s_axi_wstrb_i[0];
    end
    if (st_reg.bvalid && s_axi_bready_i) begin
      st_next.bvalid = 1'b0;
    end
    if (do_write) begin
      st_next.aw_full = 1'b0;
      st_next.w_full  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = `RESP_OKAY;
      if (!wr_addr_ok) begin
        st_next.bresp = `RESP_SLVERR;
      end else begin
        unique case (wr_idx)
          `PEND_LOW_IDX, `PEND_PIN_IDX, `PEND_HIGH_IDX, `STATUS_IDX: begin
            st_next.bresp = `RESP_OKAY;
          end
          `PORT_SEL_IDX: begin
            if (st_reg.w_lane0) begin
              st_next.port_sel = st_reg.w_data;
            end
          end
          `CTRL_IDX: begin
            if (st_reg.w_lane0) begin
              st_next.gie = st_reg.w_data[`CTRL_GIE_BIT];
            end
          end
          default: st_next.bresp = `RESP_SLVERR;
        endcase
      end
    end
    st_next.awready = ~st_next.aw_full;
    st_next.wready  = ~st_next.w_full;

    // read channel
    if (st_reg.rvalid && s_axi_rready_i) begin
      st_next.rvalid = 1'b0;
    end
    if (st_reg.arready && s_axi_arvalid_i) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = `RESP_OKAY;
      st_next.rdata  = 8'h00;
      if ((s_axi_araddr_i[1:0] != 2'h0) || (s_axi_araddr_i[15:14] != 2'h0)) begin
        st_next.rresp = `RESP_SLVERR;
      end else begin
        unique case (s_axi_araddr_i[13:2])
          `PEND_LOW_IDX:  st_next.rdata = pend_byte(st_reg.pend, `SLOT_LOW_BASE);
          `PEND_PIN_IDX:  st_next.rdata = pend_byte(st_reg.pend, `SLOT_PIN7);
          `PEND_HIGH_IDX: st_next.rdata = pend_byte(st_reg.pend, `SLOT_HIGH_BASE);
          `PORT_SEL_IDX:  st_next.rdata = st_reg.port_sel;
          `CTRL_IDX: begin
            st_next.rdata[`CTRL_GIE_BIT] = st_reg.gie;
          end
          `STATUS_IDX: begin
            st_next.rdata[4:0]            = st_reg.slot;
            st_next.rdata[`STAT_WDT_BIT]  = st_reg.pend[`SLOT_WDT];
            st_next.rdata[`STAT_TRAP_BIT] = st_reg.pend[`SLOT_TRAP];
            st_next.rdata[`STAT_IRQ_BIT]  = st_reg.irq;
          end
          default: st_next.rresp = `RESP_SLVERR;
        endcase
      end
    end
    st_next.arready = ~st_next.rvalid;

    // winner goes to the core, vector is twice the slot
    st_next.irq  = pick_bus.hit;
    st_next.slot = pick_bus.hit ? pick_bus.slot : st_reg.slot;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg          <= '0;
      st_reg.pend     <= `PEND_RESET;
      st_reg.port_sel <= `PORT_SEL_RESET;
      st_reg.gie      <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready_o = st_reg.awready;
  assign s_axi_wready_o  = st_reg.wready;
  assign s_axi_bvalid_o  = st_reg.bvalid;
  assign s_axi_bresp_o   = st_reg.bresp;
  assign s_axi_arready_o = st_reg.arready;
  assign s_axi_rvalid_o  = st_reg.rvalid;
  assign s_axi_rresp_o   = st_reg.rresp;
  assign s_axi_rdata_o   = {24'h000000, st_reg.rdata};
  assign irq_o           = st_reg.irq;
  assign vector_o        = {10'h000, st_reg.slot, 1'b0};

endmodule

// ---- vector_irq_ctrl_test.sv ----
// Purpose: self-checking bench of the vector interrupt controller
// Assumes: core model acks every vectored request
// Notes:   random masks from a fixed seed
`include "irq_ctrl_regs.svh"
module vector_irq_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIM = 200;
  logic        clock_i = 1'b0, rst_i = 1'b1;
  logic [15:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [31:0] s_axi_wdata_i = '0;
  logic [3:0]  s_axi_wstrb_i = 4'h1;
  logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [27:0] src_req_i = '0;
  logic [7:0]  port_a_i = '0, port_d_i = '0;
  logic [3:0]  port_c_i = '0;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic        vector_ack_i, irq_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o, d;
  logic [15:0] vector_o;
  logic [15:0] taken_q[$];
  logic [11:0] ridx[6] = '{`PEND_LOW_IDX, `PEND_PIN_IDX, `PEND_HIGH_IDX, `PORT_SEL_IDX, `CTRL_IDX,
                           `STATUS_IDX};
  logic [7:0]  sel, m;
  logic [3:0]  mc;
  logic [27:0] mask;
  logic [1:0]  r;
  int          error_cnt = 0, checks = 0;

  always #12.5 clock_i = ~clock_i;

  vector_irq_ctrl dut (.clock_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .src_req_i, .port_a_i, .port_d_i, .port_c_i, .vector_ack_i, .irq_o,
    .vector_o);
  core_model core (.clock_i, .rst_i, .irq_i(irq_o), .ack_o(vector_ack_i));

  // vectors the core has taken, oldest first
  always @(posedge clock_i) if (!rst_i && vector_ack_i && irq_o) taken_q.push_back(vector_o);

  task automatic final_report();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= LIM) begin
      error_cnt++;
      final_report();
    end
  endtask

  function automatic logic [15:0] ad(input logic [11:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  function automatic logic [15:0] vec_of(input int s);
    return 16'(2 * s);
  endfunction

  task automatic wr(input logic [11:0] i, input logic [7:0] v);
    int n;
    @(posedge clock_i);
    s_axi_awaddr_i  <= ad(i);
    s_axi_wdata_i   <= {24'h0, v};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    for (n = 0; n < LIM; n++) begin
      @(posedge clock_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o) break;
    end
    tmo(n);
    s_axi_bready_i <= 1'b0;
    chk(s_axi_bresp_o, `RESP_OKAY);
  endtask

  task automatic rd(input logic [15:0] a);
    int n;
    @(posedge clock_i);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    for (n = 0; n < LIM; n++) begin
      @(posedge clock_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o) break;
    end
    tmo(n);
    s_axi_rready_i <= 1'b0;
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
  endtask

  task automatic expect_vec(input logic [15:0] v);
    int n;
    for (n = 0; n < LIM && taken_q.size() == 0; n++) @(negedge clock_i);
    tmo(n);
    chk(taken_q.pop_front(), v);
  endtask

  task automatic pulse(input logic [27:0] v);
    @(posedge clock_i);
    src_req_i <= v;
    @(posedge clock_i);
    src_req_i <= '0;
  endtask

  initial begin
    void'($urandom(74196));
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) @(negedge clock_i);
    chk({irq_o, vector_o}, 32'h0);
    foreach (ridx[i]) begin
      rd(ad(ridx[i]));
      chk(d, 32'h0);
      chk(r, `RESP_OKAY);
    end
    rd(ad(`PEND_PIN_IDX) | 16'h0001);
    chk(d, 32'h0);
    chk(r, `RESP_SLVERR);
    // polled: latch pins and peripheral bits with global enable off
    sel  = 8'($urandom);
    m    = 8'($urandom);
    mc   = 4'($urandom);
    mask = 28'($urandom) & 28'h0000e00;
    wr(`PORT_SEL_IDX, sel);
    rd(ad(`PORT_SEL_IDX));
    chk(d, {24'h0, sel});
    // a write with lane 0 off leaves the select untouched
    s_axi_wstrb_i <= 4'h0;
    wr(`PORT_SEL_IDX, ~sel);
    s_axi_wstrb_i <= 4'h1;
    rd(ad(`PORT_SEL_IDX));
    chk(d, {24'h0, sel});
    @(posedge clock_i);
    port_a_i <= port_a_i ^ m;
    port_d_i <= port_d_i ^ ~m;
    port_c_i <= port_c_i ^ mc;
    pulse(mask);
    repeat (10) @(posedge clock_i);
    rd(ad(`PEND_PIN_IDX));
    chk(d, {24'h0, m ^ sel});
    rd(ad(`PEND_HIGH_IDX));
    chk(d, {28'h0, mc});
    rd(ad(`PEND_LOW_IDX));
    chk(d, {29'h0, mask[9], mask[10], mask[11]});
    @(negedge clock_i);
    chk(irq_o, 1'b0);
    for (int i = 0; i < 3; i++) begin
      wr(ridx[i], 8'hff);
      rd(ad(ridx[i]));
      chk(d, 32'h0);
    end
    // trap goes through, watchdog and timer wait for global enable
    pulse(28'h000001c);
    expect_vec(16'h0006);
    repeat (10) @(negedge clock_i);
    chk(taken_q.size(), 32'h0);
    // watchdog still pending, no request shown, last winner was the trap
    rd(ad(`STATUS_IDX));
    chk(d, {24'h0, 3'b001, 5'(`SLOT_TRAP)});
    wr(`CTRL_IDX, 8'h01);
    expect_vec(16'h0004);
    expect_vec(16'h0008);
    for (int k = 0; k < 8; k++) begin
      mask = (k == 0) ? 28'h0f00ffc : 28'($urandom) & 28'h0f00ffc;
      pulse(mask);
      for (int s = 2; s < 28; s++) if (mask[s]) expect_vec(vec_of(s));
    end
    for (int x = 0; x < 12; x++) begin
      @(posedge clock_i);
      if (x > 7) port_c_i[x - 8] <= ~port_c_i[x - 8];
      else if (sel[x]) port_d_i[x] <= ~port_d_i[x];
      else port_a_i[x] <= ~port_a_i[x];
      expect_vec(vec_of(x > 7 ? 35 - x : 19 - x));
    end
    @(posedge clock_i);
    port_a_i <= port_a_i ^ sel;
    port_d_i <= port_d_i ^ ~sel;
    repeat (12) @(negedge clock_i);
    chk(taken_q.size(), 32'h0);
    // mid-run reset while pins move: registers back to reset, no false edge
    @(posedge clock_i);
    rst_i    <= 1'b1;
    port_c_i <= ~port_c_i;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) @(negedge clock_i);
    chk({irq_o, vector_o}, 32'h0);
    repeat (6) @(negedge clock_i);
    foreach (ridx[i]) begin
      rd(ad(ridx[i]));
      chk(d, 32'h0);
    end
    final_report();
  end
endmodule
